// File: hw/banked_mem_cfg.svh
// Constants for the banked data memory decoder: offsets, ranges, resets.
// Assumes inclusion by the package and the design modules of this block.
`ifndef BANKED_MEM_CFG_SVH
`define BANKED_MEM_CFG_SVH

// ==================================================
// Program counter
`define PC_WIDTH 13
`define PC_LOW_WIDTH 8
`define PC_HIGH_WIDTH 5
`define GOTO_WIDTH 11
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`define PC_STEP 13'h0001

// ==================================================
// Register offsets inside each bank
`define ADDR_IND_PORT 7'h00
`define ADDR_PC_LOW 7'h02
`define ADDR_CORE_STATUS 7'h03
`define ADDR_IND_POINTER 7'h04
`define ADDR_PC_HIGH 7'h0A
`define SPECIAL_LIMIT 7'h20

// ==================================================
// Status fields and reset values
`define BIT_IND_BANK 7
`define BIT_BANK_HIGH 6
`define BIT_BANK_LOW 5
`define STATUS_RESET 8'h18
`define STATUS_WR_MASK 8'hE7
`define POINTER_RESET 8'h00
`define PC_HIGH_RESET 5'h00

// ==================================================
// General purpose ram ranges and index offsets
`define RAM_BANK0_LO_LARGE 8'h20
`define RAM_BANK0_LO_SMALL 8'h40
`define RAM_BANK1_LO 8'hA0
`define RAM_BANK1_HI 8'hBF
`define RAM_MIRROR_LO 8'hF0
`define RAM_BANK1_TOP 8'h80
`define RAM_OFS_BANK0 8'h20
`define RAM_OFS_BANK1 8'h40
`define RAM_OFS_MIRROR 8'hA0
`define RAM_INDEX_WIDTH 7
`define DATA_WIDTH 8

`endif

// File: hw/banked_mem_pkg.sv
// Types shared by the banked data memory decoder modules.
// Assumes the constants header sits in the include path.
`include "banked_mem_cfg.svh"

package banked_mem_pkg;

  // ==================================================
  // Kind of location that a data address reaches.
  typedef enum logic [6:0] {
    K_NONE = 7'b0000001,
    K_RAM = 7'b0000010,
    K_PC_LOW = 7'b0000100,
    K_STATUS = 7'b0001000,
    K_POINTER = 7'b0010000,
    K_PC_HIGH = 7'b0100000,
    K_INDIRECT = 7'b1000000
  } access_kind_t;

endpackage

// File: hw/gpr_storage.sv
// Small general purpose data memory with registered read data.
// Assumes one access per cycle from the decoder on the same clock.
`timescale 1ns/10ps
`include "banked_mem_cfg.svh"

module gpr_storage #(
  parameter int DEPTH = 128,
  parameter int AW = `RAM_INDEX_WIDTH,
  parameter int DW = `DATA_WIDTH
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  // ==================================================
  // Storage array and read register.
  logic [DW-1:0] mem_reg [DEPTH];
  logic [DW-1:0] rdata_reg;

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_reg <= mem_reg[addr_i];
    end
  end

  assign rdata_o = rdata_reg;

endmodule // gpr_storage

// File: hw/banked_data_memory_decoder.sv
// Program counter and bank-selected data memory of a small 8-bit core.
// Assumes the core issues at most one data access per cycle on clk_i.
`timescale 1ns/10ps
`include "banked_mem_cfg.svh"

module banked_data_memory_decoder
  import banked_mem_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int PROG_AW = 11
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic pc_inc_i,
  input wire logic pc_load_i,
  input wire logic [`GOTO_WIDTH-1:0] pc_target_i,
  input wire logic irq_take_i,
  input wire logic data_rd_i,
  input wire logic data_wr_i,
  input wire logic [6:0] data_addr_i,
  input wire logic [`DATA_WIDTH-1:0] data_wdata_i,
  output logic [`PC_WIDTH-1:0] pc_o,
  output logic [`PC_WIDTH-1:0] fetch_addr_o,
  output logic [`DATA_WIDTH-1:0] status_o,
  output logic [`DATA_WIDTH-1:0] rdata_o,
  output logic rdata_valid_o
);

  // ==================================================
  // Address decode functions.
  function automatic access_kind_t decode_kind(input logic [7:0] a);
    access_kind_t k;
    k = K_NONE;
    if (a[6:0] < `SPECIAL_LIMIT) begin
      case (a[6:0])
        `ADDR_IND_PORT: k = K_INDIRECT;
        `ADDR_PC_LOW: k = K_PC_LOW;
        `ADDR_CORE_STATUS: k = K_STATUS;
        `ADDR_IND_POINTER: k = K_POINTER;
        `ADDR_PC_HIGH: k = K_PC_HIGH;
        default: k = K_NONE;
      endcase
    end else if (a >= `RAM_MIRROR_LO) begin
      k = K_RAM;
    end else if (!a[7] && a >= (LARGE_VARIANT ? `RAM_BANK0_LO_LARGE : `RAM_BANK0_LO_SMALL)) begin
      k = K_RAM;
    end else if (LARGE_VARIANT && a >= `RAM_BANK1_LO && a <= `RAM_BANK1_HI) begin
      k = K_RAM;
    end
    return k;
  endfunction

  function automatic logic [`RAM_INDEX_WIDTH-1:0] ram_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `RAM_OFS_BANK1;
    if (a >= `RAM_MIRROR_LO) begin
      d = a - `RAM_OFS_MIRROR;
    end else if (a < `RAM_BANK1_TOP) begin
      d = a - `RAM_OFS_BANK0;
    end
    return d[`RAM_INDEX_WIDTH-1:0];
  endfunction

  // ==================================================
  // Registers.
  logic [`PC_WIDTH-1:0] pc_reg, pc_next;
  logic [`PC_WIDTH-1:0] fetch_reg, fetch_next;
  logic [`DATA_WIDTH-1:0] status_reg, status_next;
  logic [`DATA_WIDTH-1:0] pointer_reg, pointer_next;
  logic [`PC_HIGH_WIDTH-1:0] pc_high_reg, pc_high_next;
  access_kind_t kind_reg, kind_next;
  logic [`DATA_WIDTH-1:0] special_reg, special_next;
  logic pend_reg, pend_next;
  logic [`DATA_WIDTH-1:0] rdata_reg, rdata_next;
  logic valid_reg, valid_next;

  logic [7:0] direct_addr;
  logic [7:0] eff_addr;
  access_kind_t first_kind;
  access_kind_t eff_kind;
  logic [`RAM_INDEX_WIDTH-1:0] ram_idx;
  logic [`DATA_WIDTH-1:0] ram_q;
  logic ram_we;
  logic ram_re;
  logic [`PC_WIDTH-1:0] prog_mask;

  // ==================================================
  // Effective data address.
  assign direct_addr = {status_reg[`BIT_BANK_LOW], data_addr_i};
  assign first_kind = decode_kind(direct_addr);
  // Indirect accesses take all eight address bits from the pointer; status bit 7 is not used.
  assign eff_addr = (first_kind == K_INDIRECT) ? pointer_reg : direct_addr;
  assign eff_kind = decode_kind(eff_addr);
  assign ram_idx = ram_index(eff_addr);
  assign ram_we = data_wr_i && (eff_kind == K_RAM);
  assign ram_re = data_rd_i && (eff_kind == K_RAM);
  assign prog_mask = `PC_WIDTH'((1 << PROG_AW) - 1);

  gpr_storage #(
    .DEPTH(128),
    .AW(`RAM_INDEX_WIDTH),
    .DW(`DATA_WIDTH)
  ) u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .re_i(ram_re),
    .addr_i(ram_idx),
    .wdata_i(data_wdata_i),
    .rdata_o(ram_q)
  );

  // ==================================================
  // Program counter and core registers.
  always_comb begin
    pc_next = pc_reg;
    status_next = status_reg;
    pointer_next = pointer_reg;
    pc_high_next = pc_high_reg;
    if (pc_inc_i) begin
      pc_next = pc_reg + `PC_STEP;
    end
    if (pc_load_i) begin
      pc_next = {pc_high_reg[4:3], pc_target_i};
    end
    if (data_wr_i) begin
      case (eff_kind)
        K_PC_LOW: pc_next = {pc_high_reg, data_wdata_i};
        K_STATUS: status_next = (status_reg & ~`STATUS_WR_MASK) |
                                (data_wdata_i & `STATUS_WR_MASK);
        K_POINTER: pointer_next = data_wdata_i;
        K_PC_HIGH: pc_high_next = data_wdata_i[`PC_HIGH_WIDTH-1:0];
        default: pc_next = pc_next;
      endcase
    end
    if (irq_take_i) begin
      pc_next = `IRQ_VECTOR;
    end
    if (reset_i) begin
      pc_next = `RESET_VECTOR;
      status_next = `STATUS_RESET;
      pointer_next = `POINTER_RESET;
      pc_high_next = `PC_HIGH_RESET;
    end
    fetch_next = pc_next & prog_mask;
  end

  always_ff @(posedge clk_i) begin
    pc_reg <= pc_next;
    fetch_reg <= fetch_next;
    status_reg <= status_next;
    pointer_reg <= pointer_next;
    pc_high_reg <= pc_high_next;
  end

  // ==================================================
  // Read pipeline.
  always_comb begin
    kind_next = eff_kind;
    pend_next = data_rd_i && !reset_i;
    case (eff_kind)
      K_PC_LOW: special_next = pc_reg[`PC_LOW_WIDTH-1:0];
      K_STATUS: special_next = status_reg;
      K_POINTER: special_next = pointer_reg;
      K_PC_HIGH: special_next = {3'h0, pc_high_reg};
      default: special_next = 8'h00;
    endcase
    // Read data stands until the next answer or a reset.
    rdata_next = rdata_reg;
    if (pend_reg) begin
      rdata_next = (kind_reg == K_RAM) ? ram_q : special_reg;
    end
    valid_next = pend_reg;
    if (reset_i) begin
      kind_next = K_NONE;
      special_next = 8'h00;
      rdata_next = 8'h00;
      valid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    kind_reg <= kind_next;
    special_reg <= special_next;
    pend_reg <= pend_next;
    rdata_reg <= rdata_next;
    valid_reg <= valid_next;
  end

  assign pc_o = pc_reg;
  assign fetch_addr_o = fetch_reg;
  assign status_o = status_reg;
  assign rdata_o = rdata_reg;
  assign rdata_valid_o = valid_reg;

  // ==================================================
  // Checks.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence read_none_s;
    data_rd_i && eff_kind == K_NONE;
  endsequence

  sequence answer_zero_s;
    ##2 rdata_valid_o && rdata_o == 8'h00;
  endsequence

  reset_vector_a: assert property (disable iff (1'b0) reset_i |=> pc_o == 13'h0000)
    else $error("Program counter not at reset vector.");
  irq_vector_a: assert property (irq_take_i |=> pc_o == 13'h0004 && fetch_addr_o == 13'h0004)
    else $error("Interrupt did not reach vector.");
  pc_step_a: assert property (pc_inc_i && !pc_load_i && !irq_take_i && !data_wr_i
      |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("Program counter did not step.");
  fetch_wrap_a: assert property ((fetch_addr_o >> PROG_AW) == 13'h0000
      && fetch_addr_o[PROG_AW-1:0] == pc_o[PROG_AW-1:0])
    else $error("Fetch address not wrapped.");
  unimpl_zero_a: assert property (read_none_s |-> answer_zero_s)
    else $error("Unimplemented location read non-zero.");
  special_window_a: assert property (data_rd_i && eff_addr[6:0] < 7'h20 |-> eff_kind != K_RAM)
    else $error("Special window decoded as ram.");
  mirror_share_a: assert property (ram_we && eff_addr >= 8'hF0 |-> ram_idx[6:4] == 3'h5)
    else $error("Mirror did not reach shared bytes.");
  bank_select_a: assert property (data_wr_i && first_kind != K_INDIRECT
      |-> eff_addr[7] == status_o[5])
    else $error("Direct address ignores bank bit.");
  indirect_path_a: assert property (data_rd_i && first_kind == K_INDIRECT |-> eff_addr == pointer_reg)
    else $error("Indirect access not through pointer.");
  status_write_a: assert property (data_wr_i && eff_kind == K_STATUS && !irq_take_i
      |=> (status_o & 8'hE7) == ($past(data_wdata_i) & 8'hE7))
    else $error("Status bank bits not written.");
  read_latency_a: assert property (data_rd_i |-> ##2 rdata_valid_o)
    else $error("Read answer missing.");

endmodule // banked_data_memory_decoder

// File: tb/core_model.sv
// Processor core model that issues data port accesses to the decoder.
// Assumes the decoder clock and a read answer within five cycles.
`timescale 1ns/10ps
module core_model (
  input wire logic clk_i,
  input wire logic rdata_valid_i,
  input wire logic [7:0] rdata_i,
  output logic rd_o,
  output logic wr_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  // ==================================================
  // Idle values.
  initial begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 7'h00;
    wdata_o = 8'h00;
  end

  // ==================================================
  // One access: a one-cycle request, then, for a read only, a bounded wait for read data.
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    int n;
    q = 8'h00;
    n = 0;
    @(posedge clk_i);
    rd_o <= ~wr;
    wr_o <= wr;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    if (!wr) begin
      do begin
        @(negedge clk_i);
        n++;
      end while (rdata_valid_i !== 1'b1 && n < 5);
      // A missing answer shows as unknown so that the compare fails.
      q = (rdata_valid_i === 1'b1) ? rdata_i : 8'hXX;
    end
  endtask
endmodule // core_model

// File: tb/banked_data_memory_decoder_tb_top.sv
// Self-checking bench for the banked data memory decoder, large variant.
// Assumes the design package and header are compiled first.
`timescale 1ns/10ps
module banked_data_memory_decoder_tb_top;
  typedef struct {
    logic wb;
    logic [6:0] wa;
    logic rb;
    logic [6:0] ra;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  row_t rows [8] = '{
    '{1'b0, 7'h20, 1'b0, 7'h20, 8'h11, 8'h11}, '{1'b0, 7'h7F, 1'b0, 7'h7F, 8'h22, 8'h22},
    '{1'b1, 7'h20, 1'b1, 7'h20, 8'h33, 8'h33}, '{1'b1, 7'h3F, 1'b1, 7'h3F, 8'h44, 8'h44},
    '{1'b1, 7'h40, 1'b1, 7'h40, 8'h55, 8'h00}, '{1'b0, 7'h06, 1'b0, 7'h06, 8'h66, 8'h00},
    '{1'b0, 7'h1F, 1'b0, 7'h1F, 8'h77, 8'h00}, '{1'b1, 7'h75, 1'b0, 7'h75, 8'h88, 8'h88}};
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic pc_inc_i = 1'b0;
  logic pc_load_i = 1'b0;
  logic irq_take_i = 1'b0;
  logic [10:0] pc_target_i = 11'h000;
  logic data_rd_i, data_wr_i, rdata_valid_o;
  logic [6:0] data_addr_i;
  logic [7:0] data_wdata_i, status_o, rdata_o, q;
  logic [12:0] pc_o, fetch_addr_o;
  logic [12:0] fetch_small;
  logic [7:0] rdata_small;
  int errors = 0;
  int checked = 0;

  always #10 clk_i = ~clk_i;

  banked_data_memory_decoder #(.LARGE_VARIANT(1'b1), .PROG_AW(11)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .pc_inc_i(pc_inc_i), .pc_load_i(pc_load_i),
    .pc_target_i(pc_target_i), .irq_take_i(irq_take_i), .data_rd_i(data_rd_i),
    .data_wr_i(data_wr_i), .data_addr_i(data_addr_i), .data_wdata_i(data_wdata_i),
    .pc_o(pc_o), .fetch_addr_o(fetch_addr_o), .status_o(status_o), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o));

  // Small variant on the same bus, checked at ram 40h and 20h and on its fetch address after wrap and load.
  banked_data_memory_decoder #(.LARGE_VARIANT(1'b0), .PROG_AW(10)) u_dut_small (
    .clk_i(clk_i), .reset_i(reset_i), .pc_inc_i(pc_inc_i), .pc_load_i(pc_load_i),
    .pc_target_i(pc_target_i), .irq_take_i(irq_take_i), .data_rd_i(data_rd_i),
    .data_wr_i(data_wr_i), .data_addr_i(data_addr_i), .data_wdata_i(data_wdata_i),
    .pc_o(), .fetch_addr_o(fetch_small), .status_o(), .rdata_o(rdata_small),
    .rdata_valid_o());

  core_model u_core (
    .clk_i(clk_i), .rdata_valid_i(rdata_valid_o), .rdata_i(rdata_o), .rd_o(data_rd_i),
    .wr_o(data_wr_i), .addr_o(data_addr_i), .wdata_o(data_wdata_i));

  // ==================================================
  // Shared tasks.
  task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_core.access(1'b1, a, d, q);
    @(negedge clk_i);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e, input string what);
    u_core.access(1'b0, a, 8'h00, q);
    check({5'h00, q}, {5'h00, e}, what);
  endtask

  task automatic set_bank(input logic b);
    wr(7'h03, {2'b00, b, 5'h00});
    check({5'h00, status_o}, {5'h00, 2'b00, b, 5'h18}, "bank select");
  endtask

  task automatic end_of_test();
    $display("counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==================================================
  // Watchdog.
  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  // ==================================================
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check(pc_o, 13'h0000, "pc reset");
    check({5'h00, status_o}, 13'h0018, "status reset");
    rd_chk(7'h0A, 8'h00, "latch reset");
    $display("test reset done");
    foreach (rows[i]) begin
      set_bank(rows[i].wb);
      wr(rows[i].wa, rows[i].d);
      set_bank(rows[i].rb);
      rd_chk(rows[i].ra, rows[i].e, "table");
    end
    $display("test table done");
    wr(7'h03, 8'h60);
    check({5'h00, status_o}, 13'h0078, "high bank");
    rd_chk(7'h3F, 8'h44, "bank 3 folds");
    set_bank(1'b0);
    wr(7'h04, 8'h30);
    wr(7'h00, 8'h5A);
    rd_chk(7'h30, 8'h5A, "indirect write");
    rd_chk(7'h00, 8'h5A, "indirect read");
    wr(7'h04, 8'hA5);
    wr(7'h00, 8'h6B);
    set_bank(1'b1);
    rd_chk(7'h25, 8'h6B, "indirect bank 1");
    set_bank(1'b0);
    wr(7'h40, 8'h99);
    rd_chk(7'h40, 8'h99, "ram 40h");
    check({5'h00, rdata_small}, 13'h0099, "small ram 40h");
    rd_chk(7'h20, 8'h11, "ram 20h");
    check({5'h00, rdata_small}, 13'h0000, "small 20h zero");
    @(negedge clk_i);
    check({12'h000, rdata_valid_o}, 13'h0000, "valid one cycle");
    check({5'h00, rdata_o}, 13'h0011, "read data holds");
    $display("test data done");
    @(posedge clk_i);
    pc_inc_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    pc_inc_i <= 1'b0;
    @(negedge clk_i);
    check(pc_o, 13'h0003, "pc step");
    wr(7'h0A, 8'hFF);
    rd_chk(7'h0A, 8'h1F, "latch bits");
    wr(7'h02, 8'hFF);
    @(negedge clk_i);
    check(pc_o, 13'h1FFF, "pc top");
    check(fetch_addr_o, 13'h07FF, "fetch wrap");
    check(fetch_small, 13'h03FF, "small fetch wrap");
    @(posedge clk_i);
    pc_target_i <= 11'h123;
    pc_load_i <= 1'b1;
    @(posedge clk_i);
    pc_load_i <= 1'b0;
    @(negedge clk_i);
    check(pc_o, 13'h1923, "pc load");
    check(fetch_addr_o, 13'h0123, "load wrap");
    check(fetch_small, 13'h0123, "small load wrap");
    @(posedge clk_i);
    irq_take_i <= 1'b1;
    pc_inc_i <= 1'b1;
    @(posedge clk_i);
    irq_take_i <= 1'b0;
    pc_inc_i <= 1'b0;
    @(negedge clk_i);
    check(pc_o, 13'h0004, "irq vector");
    @(posedge clk_i);
    reset_i <= 1'b1;
    @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check(pc_o, 13'h0000, "pc rereset");
    check({5'h00, status_o}, 13'h0018, "status rereset");
    rd_chk(7'h20, 8'h11, "ram kept");
    $display("test program counter done");
    end_of_test();
  end
endmodule // banked_data_memory_decoder_tb_top
